/* hw/modrm_decode_pkg.sv */
// Constants and types for the operand-addressing decoder
package modrm_decode_pkg;
  // ----------------------------------------------------------------
  // Addressing-form field codes
  // ----------------------------------------------------------------
  localparam logic [1:0] MOD_NO_DISP = 2'h0;
  localparam logic [1:0] MOD_DISP8 = 2'h1;
  localparam logic [1:0] MOD_DISP16 = 2'h2;
  localparam logic [1:0] MOD_REGISTER = 2'h3;

  // ----------------------------------------------------------------
  // Field positions in the addressing byte and the opcode byte
  // ----------------------------------------------------------------
  localparam int MOD_HI = 7;
  localparam int MOD_LO = 6;
  localparam int REG_HI = 5;
  localparam int REG_LO = 3;
  localparam int RM_HI = 2;
  localparam int RM_LO = 0;
  localparam int WIDTH_BIT = 0;

  // ----------------------------------------------------------------
  // Segment override prefix: 001 ss 110
  // ----------------------------------------------------------------
  localparam logic [2:0] PREFIX_TOP = 3'h1;
  localparam logic [2:0] PREFIX_BOTTOM = 3'h6;

  // Direct address form: mod 00 with r/m 110
  localparam logic [2:0] RM_DIRECT = 3'h6;

  // ----------------------------------------------------------------
  // Segment codes
  // ----------------------------------------------------------------
  localparam logic [1:0] SEG_EXTRA = 2'h0;
  localparam logic [1:0] SEG_CODE = 2'h1;
  localparam logic [1:0] SEG_STACK = 2'h2;
  localparam logic [1:0] SEG_DATA = 2'h3;

  // ----------------------------------------------------------------
  // Word register indices (accum, count, data, base, stack ptr, base ptr, src, dest)
  // ----------------------------------------------------------------
  localparam logic [2:0] IDX_ACCUM = 3'h0;
  localparam logic [2:0] IDX_BASE = 3'h3;
  localparam logic [2:0] IDX_BASE_PTR = 3'h5;
  localparam logic [2:0] IDX_SRC = 3'h6;
  localparam logic [2:0] IDX_DEST = 3'h7;

  // Operand lane: whole word, low byte, high byte
  localparam logic [1:0] LANE_WORD = 2'h0;
  localparam logic [1:0] LANE_LOW = 2'h1;
  localparam logic [1:0] LANE_HIGH = 2'h2;

  // Reset values
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [7:0] BYTE_RST = 8'h00;

  typedef enum logic [2:0] {
    ST_OPCODE,
    ST_MODRM,
    ST_DISP_LOW,
    ST_DISP_HIGH,
    ST_FINISH
  } dec_state_e;
endpackage

/* hw/modrm_effective_address_decode.sv */
// Operand-addressing decoder: width, displacement, effective address, registers
//
// Contract
// - Width bit 1 word, 0 byte
// - Form 11: operand field names a register
// - Form 00: zero displacement, no bytes, except r/m 110 which takes two address bytes
// - Form 01: one byte, sign-extended
// - Form 10: two bytes, second is high
// - Displacement follows the addressing byte
// - Codes 000-011: base plus index plus displacement
// - Codes 100-111: one register plus displacement
// - Word register order accum to dest index
// - Prefix 001 ss 110 overrides next segment
`timescale 1ns/10ps
`default_nettype none
module modrm_effective_address_decode
  import modrm_decode_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic byte_valid,
  input wire logic [7:0] byte_data,
  input wire logic [15:0] accum_word,
  input wire logic [15:0] count_word,
  input wire logic [15:0] data_word,
  input wire logic [15:0] base_word,
  input wire logic [15:0] stack_pointer,
  input wire logic [15:0] base_pointer,
  input wire logic [15:0] src_index,
  input wire logic [15:0] dest_index,
  output logic byte_ready_q,
  output logic decode_valid_q,
  output logic width_word_q,
  output logic operand_is_reg_q,
  output logic [15:0] effective_addr_q,
  output logic [15:0] displacement_q,
  output logic [1:0] disp_count_q,
  output logic [2:0] reg_idx_q,
  output logic [1:0] reg_lane_q,
  output logic [2:0] rm_idx_q,
  output logic [1:0] rm_lane_q,
  output logic [1:0] segment_q,
  output logic seg_override_q
);

  dec_state_e state_q;
  logic take;
  logic wbit_q;
  logic [1:0] mod_q;
  logic [2:0] reg_q;
  logic [2:0] rm_q;
  logic [7:0] disp_low_q;
  logic [7:0] disp_high_q;
  logic ovr_pend_q;
  logic [1:0] ovr_seg_q;
  logic is_prefix;
  logic [15:0] disp_d;
  logic [15:0] eff_addr_d;
  logic [1:0] seg_d;

  assign take = byte_valid && byte_ready_q;
  assign is_prefix = (byte_data[7:5] == PREFIX_TOP) && (byte_data[2:0] == PREFIX_BOTTOM);

  // ----------------------------------------------------------------
  // Byte sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_q <= ST_OPCODE;
    end else begin
      case (state_q)
        ST_OPCODE: begin
          if (take && !is_prefix) begin
            state_q <= ST_MODRM;
          end
        end
        ST_MODRM: begin
          if (take) begin
            // Displacement bytes come right after this byte
            case (byte_data[MOD_HI:MOD_LO])
              MOD_DISP8, MOD_DISP16: state_q <= ST_DISP_LOW;
              MOD_NO_DISP: begin
                if (byte_data[RM_HI:RM_LO] == RM_DIRECT) begin
                  state_q <= ST_DISP_LOW;
                end else begin
                  state_q <= ST_FINISH;
                end
              end
              default: state_q <= ST_FINISH;
            endcase
          end
        end
        ST_DISP_LOW: begin
          if (take) begin
            state_q <= (mod_q == MOD_DISP8) ? ST_FINISH : ST_DISP_HIGH;
          end
        end
        ST_DISP_HIGH: begin
          if (take) begin
            state_q <= ST_FINISH;
          end
        end
        ST_FINISH: state_q <= ST_OPCODE;
        default: state_q <= ST_OPCODE;
      endcase
    end
  end

  // No bytes taken while the result is being formed
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      byte_ready_q <= 1'b0;
    end else begin
      byte_ready_q <= !(state_q == ST_FINISH) &&
                      !((state_q == ST_DISP_HIGH) && take) &&
                      !((state_q == ST_DISP_LOW) && take && (mod_q == MOD_DISP8)) &&
                      !((state_q == ST_MODRM) && take &&
                        ((byte_data[MOD_HI:MOD_LO] == MOD_REGISTER) ||
                         ((byte_data[MOD_HI:MOD_LO] == MOD_NO_DISP) &&
                          (byte_data[RM_HI:RM_LO] != RM_DIRECT))));
    end
  end

  // ----------------------------------------------------------------
  // Field capture
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wbit_q <= 1'b0;
      mod_q <= MOD_NO_DISP;
      reg_q <= IDX_ACCUM;
      rm_q <= IDX_ACCUM;
      disp_low_q <= BYTE_RST;
      disp_high_q <= BYTE_RST;
    end else if (take) begin
      case (state_q)
        ST_OPCODE: wbit_q <= byte_data[WIDTH_BIT];
        ST_MODRM: begin
          mod_q <= byte_data[MOD_HI:MOD_LO];
          reg_q <= byte_data[REG_HI:REG_LO];
          rm_q <= byte_data[RM_HI:RM_LO];
          disp_low_q <= BYTE_RST;
          disp_high_q <= BYTE_RST;
        end
        ST_DISP_LOW: disp_low_q <= byte_data;
        ST_DISP_HIGH: disp_high_q <= byte_data;
        default: disp_low_q <= disp_low_q;
      endcase
    end
  end

  // Override holds only until the memory access it belongs to is formed
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ovr_pend_q <= 1'b0;
      ovr_seg_q <= SEG_DATA;
    end else if (take && (state_q == ST_OPCODE) && is_prefix) begin
      ovr_pend_q <= 1'b1;
      ovr_seg_q <= byte_data[4:3];
    end else if (state_q == ST_FINISH && mod_q != MOD_REGISTER) begin
      ovr_pend_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Displacement, effective address and segment
  // ----------------------------------------------------------------
  always_comb begin
    case (mod_q)
      MOD_DISP8: disp_d = {{8{disp_low_q[7]}}, disp_low_q};
      MOD_DISP16: disp_d = {disp_high_q, disp_low_q};
      default: disp_d = WORD_RST;
    endcase
  end

  always_comb begin
    seg_d = SEG_DATA;
    case (rm_q)
      3'h0: eff_addr_d = 16'(base_word + src_index + disp_d);
      3'h1: eff_addr_d = 16'(base_word + dest_index + disp_d);
      3'h2: eff_addr_d = 16'(base_pointer + src_index + disp_d);
      3'h3: eff_addr_d = 16'(base_pointer + dest_index + disp_d);
      3'h4: eff_addr_d = 16'(src_index + disp_d);
      3'h5: eff_addr_d = 16'(dest_index + disp_d);
      3'h6: eff_addr_d = 16'(base_pointer + disp_d);
      default: eff_addr_d = 16'(base_word + disp_d);
    endcase
    // Frame-pointer forms default to the stack segment
    if (rm_q == 3'h2 || rm_q == 3'h3 || rm_q == RM_DIRECT) begin
      seg_d = SEG_STACK;
    end
    if (mod_q == MOD_NO_DISP && rm_q == RM_DIRECT) begin
      eff_addr_d = {disp_high_q, disp_low_q};
      seg_d = SEG_DATA;
    end
    if (ovr_pend_q) begin
      seg_d = ovr_seg_q;
    end
  end

  // ----------------------------------------------------------------
  // Results
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      decode_valid_q <= 1'b0;
    end else begin
      decode_valid_q <= (state_q == ST_FINISH);
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      width_word_q <= 1'b0;
      operand_is_reg_q <= 1'b0;
      effective_addr_q <= WORD_RST;
      displacement_q <= WORD_RST;
      disp_count_q <= 2'h0;
      reg_idx_q <= IDX_ACCUM;
      reg_lane_q <= LANE_WORD;
      rm_idx_q <= IDX_ACCUM;
      rm_lane_q <= LANE_WORD;
      segment_q <= SEG_DATA;
      seg_override_q <= 1'b0;
    end else if (state_q == ST_FINISH) begin
      width_word_q <= wbit_q;
      operand_is_reg_q <= (mod_q == MOD_REGISTER);
      // Byte codes fold onto the first four word registers
      reg_idx_q <= wbit_q ? reg_q : {1'b0, reg_q[1:0]};
      reg_lane_q <= wbit_q ? LANE_WORD : (reg_q[2] ? LANE_HIGH : LANE_LOW);
      if (mod_q == MOD_REGISTER) begin
        rm_idx_q <= wbit_q ? rm_q : {1'b0, rm_q[1:0]};
        rm_lane_q <= wbit_q ? LANE_WORD : (rm_q[2] ? LANE_HIGH : LANE_LOW);
        effective_addr_q <= WORD_RST;
        displacement_q <= WORD_RST;
        disp_count_q <= 2'h0;
        seg_override_q <= 1'b0;
      end else begin
        rm_idx_q <= rm_q;
        rm_lane_q <= LANE_WORD;
        effective_addr_q <= eff_addr_d;
        displacement_q <= (mod_q == MOD_NO_DISP) ? WORD_RST : disp_d;
        disp_count_q <= (mod_q == MOD_DISP8) ? 2'h1 :
                        ((mod_q == MOD_DISP16 || rm_q == RM_DIRECT) ? 2'h2 : 2'h0);
        segment_q <= seg_d;
        seg_override_q <= ovr_pend_q;
      end
    end
  end

endmodule
`default_nettype wire

/* verification/modrm_decode_asserts.sv */
// Port-level checker for the operand-addressing decoder
`timescale 1ns/10ps
`default_nettype none
module modrm_decode_asserts
  import modrm_decode_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [15:0] base_word,
  input wire logic [15:0] src_index,
  input wire logic [15:0] dest_index,
  input wire logic byte_ready_q,
  input wire logic decode_valid_q,
  input wire logic width_word_q,
  input wire logic operand_is_reg_q,
  input wire logic [15:0] effective_addr_q,
  input wire logic [15:0] displacement_q,
  input wire logic [1:0] disp_count_q,
  input wire logic [1:0] reg_lane_q,
  input wire logic [2:0] rm_idx_q,
  input wire logic [1:0] segment_q,
  input wire logic seg_override_q
);
  // ----------------------------------------------------------------
  // Result properties, judged in the result cycle; pulse length also checks the cycle after, ready gap the cycles before and after
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  pulse_len_a: assert property (decode_valid_q |=> !decode_valid_q)
    else $error("result pulse too long");
  ready_gap_a: assert property (decode_valid_q |->
    (!byte_ready_q && !$past(byte_ready_q)) ##1 byte_ready_q)
    else $error("byte ready wrong around result");
  reg_form_a: assert property (decode_valid_q && operand_is_reg_q |->
    effective_addr_q == 16'h0000 && disp_count_q == 2'h0) else $error("register form bad");
  word_lane_a: assert property (decode_valid_q && width_word_q |-> reg_lane_q == LANE_WORD)
    else $error("word lane bad");
  byte_lane_a: assert property (decode_valid_q && !width_word_q |-> reg_lane_q != LANE_WORD)
    else $error("byte lane bad");
  no_disp_a: assert property (decode_valid_q && disp_count_q == 2'h0 |->
    displacement_q == 16'h0000) else $error("zero displacement bad");
  sign_ext_a: assert property (decode_valid_q && disp_count_q == 2'h1 |->
    displacement_q[15:8] == {8{displacement_q[7]}}) else $error("sign extension bad");
  count_max_a: assert property (decode_valid_q |-> disp_count_q != 2'h3)
    else $error("displacement count bad");
  pair_sum_a: assert property (decode_valid_q && !operand_is_reg_q && rm_idx_q == 3'h0 |->
    effective_addr_q == 16'($past(base_word) + $past(src_index) + displacement_q))
    else $error("base plus index sum bad");
  single_reg_a: assert property (decode_valid_q && !operand_is_reg_q && rm_idx_q == 3'h5 |->
    effective_addr_q == 16'($past(dest_index) + displacement_q)) else $error("single sum bad");
  stack_dflt_a: assert property (decode_valid_q && !operand_is_reg_q && !seg_override_q
    && rm_idx_q == 3'h3 |-> segment_q == SEG_STACK) else $error("default segment bad");
endmodule
bind modrm_effective_address_decode modrm_decode_asserts chk_i (.*);
`default_nettype wire

/* verification/tb_top.sv */
// Self-checking bench for the operand-addressing decoder
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import modrm_decode_pkg::*;
;
  logic mclk, rst, byte_valid, byte_ready_q, decode_valid_q, width_word_q;
  logic operand_is_reg_q, seg_override_q;
  logic [7:0] byte_data;
  logic [15:0] rf [8];
  logic [15:0] effective_addr_q, displacement_q;
  logic [1:0] disp_count_q, reg_lane_q, rm_lane_q, segment_q;
  logic [2:0] reg_idx_q, rm_idx_q;
  int err_count, n_tests, cycles;
  modrm_effective_address_decode dut (.mclk, .rst, .byte_valid, .byte_data,
    .accum_word(rf[0]), .count_word(rf[1]), .data_word(rf[2]), .base_word(rf[3]),
    .stack_pointer(rf[4]), .base_pointer(rf[5]), .src_index(rf[6]), .dest_index(rf[7]),
    .byte_ready_q, .decode_valid_q, .width_word_q, .operand_is_reg_q, .effective_addr_q,
    .displacement_q, .disp_count_q, .reg_idx_q, .reg_lane_q, .rm_idx_q, .rm_lane_q,
    .segment_q, .seg_override_q);
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Realign to a rising edge only after an idle gap, so a held byte is never taken twice
  task automatic put(input logic [7:0] b);
    if (!byte_valid) @(posedge mclk);
    byte_valid <= 1'b1;
    byte_data <= b;
    @(negedge mclk);
    while (byte_ready_q !== 1'b1) @(negedge mclk);
    @(posedge mclk);
  endtask
  task automatic done();
    byte_valid <= 1'b0;
    @(negedge mclk);
    chk("early", decode_valid_q, 1'b0);
    @(negedge mclk);
    chk("valid", decode_valid_q, 1'b1);
  endtask
  function automatic logic [15:0] addr_sum(input logic [2:0] rm, input logic [15:0] d);
    case (rm)
      3'h0: addr_sum = rf[3] + rf[6] + d;
      3'h1: addr_sum = rf[3] + rf[7] + d;
      3'h2: addr_sum = rf[5] + rf[6] + d;
      3'h3: addr_sum = rf[5] + rf[7] + d;
      3'h4: addr_sum = rf[6] + d;
      3'h5: addr_sum = rf[7] + d;
      3'h6: addr_sum = rf[5] + d;
      default: addr_sum = rf[3] + d;
    endcase
  endfunction
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic reg_forms();
    logic [2:0] q;
    for (int w = 0; w < 2; w++) for (int r = 0; r < 8; r++) begin
      // Distinct codes in the two fields so a swap shows up
      q = ~r[2:0];
      put({7'h00, w[0]});
      put({2'h3, r[2:0], q});
      done();
      chk("word", width_word_q, w[0]);
      chk("isreg", operand_is_reg_q, 1'b1);
      chk("ridx", reg_idx_q, w ? r[2:0] : {1'b0, r[1:0]});
      chk("rlane", reg_lane_q, w ? LANE_WORD : (r[2] ? LANE_HIGH : LANE_LOW));
      chk("rmidx", rm_idx_q, w ? q : {1'b0, q[1:0]});
      chk("rmlane", rm_lane_q, w ? LANE_WORD : (q[2] ? LANE_HIGH : LANE_LOW));
    end
  endtask
  task automatic mem_forms();
    logic [7:0] lo_b;
    logic [15:0] d;
    for (int m = 0; m < 3; m++) for (int rm = 0; rm < 8; rm++) begin
      if (m == 0 && rm == 6) continue;
      @(posedge mclk);
      for (int i = 0; i < 8; i++) rf[i] <= 16'(16'h1111 * i + 16'h0F0F * m + rm);
      lo_b = rm[0] ? 8'h85 : 8'h15;
      d = (m == 0) ? 16'h0000 : (m == 1) ? {{8{lo_b[7]}}, lo_b} : {8'h12, lo_b};
      put(8'h01);
      put({m[1:0], 3'h2, rm[2:0]});
      if (m > 0) put(lo_b);
      if (m == 2) put(8'h12);
      done();
      chk("addr", effective_addr_q, addr_sum(rm[2:0], d));
      chk("midx", rm_idx_q, rm[2:0]);
      chk("mlane", rm_lane_q, LANE_WORD);
      chk("mseg", segment_q, (rm == 2 || rm == 3 || rm == 6) ? SEG_STACK : SEG_DATA);
      chk("disp", displacement_q, d);
      chk("count", disp_count_q, m[1:0]);
      chk("isreg", operand_is_reg_q, 1'b0);
    end
  endtask
  task automatic direct_and_seg();
    put(8'h01);
    put(8'h06);
    put(8'h34);
    put(8'h12);
    done();
    chk("direct", effective_addr_q, 16'h1234);
    chk("dcount", disp_count_q, 2'h2);
    chk("dsegd", segment_q, SEG_DATA);
    for (int s = 0; s < 4; s++) begin
      put({3'h1, s[1:0], 3'h6});
      put(8'h01);
      put(8'h00);
      done();
      chk("seg", segment_q, s[1:0]);
      chk("ovr", seg_override_q, 1'b1);
    end
    put(8'h01);
    put(8'h43);
    put(8'h00);
    done();
    chk("dseg", segment_q, SEG_STACK);
    chk("dovr", seg_override_q, 1'b0);
  endtask
  // ----------------------------------------------------------------
  // Clock, reset, timeout and main sequence
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      err_count++;
      print_verdict();
    end
  end
  initial begin
    rst = 1'b1;
    byte_valid = 1'b0;
    byte_data = 8'h00;
    for (int i = 0; i < 8; i++) rf[i] = 16'h0101 * i;
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    reg_forms();
    mem_forms();
    direct_and_seg();
    print_verdict();
  end
endmodule
`default_nettype wire
